/* hdl/clbc_pkg.sv */
/*
  Constants, types and register map of the counter limit and bus config block.
  Assumes a single 125 MHz clock and a word wide parameter access port.
*/
package clbc_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] OFS_LIMIT_SEL   = 16'h0d05;
  localparam logic [15:0] OFS_SAFE_SP     = 16'h0d06;
  localparam logic [15:0] OFS_RST_MASK    = 16'h0d09;
  localparam logic [15:0] OFS_SIDE_ADDR   = 16'h0f8a;
  localparam logic [15:0] OFS_SIDE_PAR    = 16'h0f8c;
  localparam logic [15:0] OFS_TOP_ADDR    = 16'h0faa;
  localparam logic [15:0] OFS_TOP_PAR     = 16'h0fac;
  localparam logic [15:0] OFS_SLV_FACTOR  = 16'ha108;
  localparam logic [15:0] OFS_SIDE_BAUD   = 16'hfc48;
  localparam logic [15:0] OFS_TOP_BAUD    = 16'hfd48;
  localparam logic [15:0] OFS_MASTER_NODE = 16'h0f00;
  // ------------------------------------------------------------
  // Reset values and ranges
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_LIMIT_SEL   = 8'h00;
  localparam logic [15:0] RST_SAFE_SP     = 16'h0000;
  localparam logic [7:0]  RST_RST_MASK    = 8'h07;
  localparam logic [7:0]  RST_NODE_ADDR   = 8'h03;
  localparam logic [7:0]  RST_PARITY      = 8'h00;
  localparam logic [31:0] RST_BAUD        = 32'h0001_c200;
  localparam logic [31:0] RST_SLV_FACTOR  = 32'h0000_0064;
  localparam logic [7:0]  RST_MASTER_NODE = 8'h01;
  localparam logic [15:0] SP_FULL_SCALE   = 16'h7d00;
  localparam logic [31:0] SLV_FACTOR_MAX  = 32'h0000_01f4;
  localparam logic [31:0] PERCENT_FULL    = 32'h0000_0064;
  localparam logic [7:0]  NODE_MAX        = 8'h80;
  // ------------------------------------------------------------
  // Field positions and mode codes
  // ------------------------------------------------------------
  localparam int          RM_SWITCH_BIT   = 0;
  localparam int          RM_EXTERN_BIT   = 1;
  localparam int          RM_PARAM_BIT    = 2;
  localparam int          RM_AUTO_BIT     = 3;
  localparam logic [7:0]  CTRL_SLAVE_DIG  = 8'h02;
  localparam logic [7:0]  CTRL_SLAVE_ANA  = 8'h0d;
  localparam logic [1:0]  CNT_MODE_LIMIT  = 2'h2;
  localparam logic [7:0]  SEL_SAFE        = 8'h01;
  localparam int          POLL_US         = 100;
  localparam int          CLK_MHZ         = 125;
  localparam int          POLL_CYCLES     = POLL_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ODD  = 2'b01,
    PAR_EVEN = 2'b10,
    PAR_BAD  = 2'b11
  } clbc_parity_t;

  typedef enum logic [1:0] {
    CS_RUN  = 2'b00,
    CS_SAFE = 2'b01
  } clbc_cstate_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] baud;
    clbc_parity_t parity;
  } clbc_port_cfg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } clbc_req_t;
endpackage

/* hdl/clbc_top.sv */
/*
  Parameter bank: counter limit action, two serial port configs, slave setpoint.
  Assumes accesses come from the serial protocol engine, one per cycle, with
  the source port flagged; the setpoint loop and the poll engine sit outside.
*/
// Contract
// - Limit keeps setpoint or selects safe setpoint
// - Safe setpoint held until enabled reset
// - Safe setpoint unsigned 0..32000 full span
// - Reset mask bits switch, external, parameter, auto
// - Reset mask initialises to seven
// - Parity code 0 none, 1 odd, 2 even
// - Factory restore leaves network settings alone
// - Top port settings writable over RS232
// - Side RS485 ignores RS232 unless configuration mode
// - Configuration mode persists until switch toggles it
// - Slave when control mode is 2 or 13
// - Slave polls master output periodically
// - Master node 1..128, proprietary bus only
// - Slave setpoint is output times factor over 100
// - Other networks: factor only analog slave, analog fed
// - Slave still publishes its own output
// - Own output readable by every node
// - Limit event only in counter mode 2
`timescale 1ns/1ns
module clbc_top
  import clbc_pkg::*;
#(
  parameter int POLL_LEN = POLL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire clbc_req_t   req,
  input  wire logic        req_rs232,
  input  wire logic        side_rs485,
  input  wire logic        cfg_mode_stored,
  input  wire logic        switch_cfg_toggle,
  input  wire logic        factory_restore,
  input  wire logic [1:0]  counter_mode,
  input  wire logic        counter_at_limit,
  input  wire logic        rst_switch,
  input  wire logic        rst_extern,
  input  wire logic        rst_param,
  input  wire logic        counter_cleared,
  input  wire logic [15:0] present_sp,
  input  wire logic [7:0]  control_mode,
  input  wire logic        net_is_fieldbus,
  input  wire logic        analog_master_fed,
  input  wire logic [15:0] master_output,
  input  wire logic        master_output_vld,
  input  wire logic [15:0] own_output,
  output logic             req_ack,
  output logic             req_err,
  output logic [31:0]      rdata,
  output logic             cfg_mode,
  output logic [15:0]      effective_sp,
  output logic             safe_active,
  output logic             slave_active,
  output logic             poll_req,
  output logic [7:0]       poll_node,
  output logic [15:0]      slave_sp,
  output logic [15:0]      published_output,
  output clbc_port_cfg_t   top_cfg,
  output clbc_port_cfg_t   side_cfg
);
  if (POLL_LEN < 1) begin : g_poll_len_check
    $error("POLL_LEN must be at least one");
  end

  function automatic clbc_parity_t decode_parity(input logic [7:0] code);
    decode_parity = (code > 8'h02) ? PAR_BAD : clbc_parity_t'(code[1:0]);
  endfunction

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0]   limit_sel_r;
  logic [15:0]  safe_sp_r;
  logic [7:0]   rst_mask_r;
  logic [7:0]   top_addr_r;
  logic [7:0]   top_par_r;
  logic [31:0]  top_baud_r;
  logic [7:0]   side_addr_r;
  logic [7:0]   side_par_r;
  logic [31:0]  side_baud_r;
  logic [31:0]  slv_factor_r;
  logic [7:0]   master_node_r;
  logic         cfg_mode_r;
  logic         cfg_loaded_r;
  clbc_cstate_t cstate_r;
  clbc_cstate_t cstate_nxt;
  logic [31:0]  rdata_r;
  logic [15:0]  slave_sp_r;
  logic [15:0]  pub_r;
  logic [31:0]  poll_cnt_r;
  logic         poll_r;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  // Side RS485 blocks RS232 outside configuration mode
  wire rs232_blocked = req_rs232 && side_rs485 && !cfg_mode_r;
  wire acc           = (req.wr || req.rd) && !rs232_blocked;
  wire wr            = req.wr && !rs232_blocked;
  wire hit_sel   = req.addr == OFS_LIMIT_SEL;
  wire hit_sp    = req.addr == OFS_SAFE_SP;
  wire hit_mask  = req.addr == OFS_RST_MASK;
  wire hit_saddr = req.addr == OFS_SIDE_ADDR;
  wire hit_spar  = req.addr == OFS_SIDE_PAR;
  wire hit_taddr = req.addr == OFS_TOP_ADDR;
  wire hit_tpar  = req.addr == OFS_TOP_PAR;
  wire hit_fac   = req.addr == OFS_SLV_FACTOR;
  wire hit_sbaud = req.addr == OFS_SIDE_BAUD;
  wire hit_tbaud = req.addr == OFS_TOP_BAUD;
  wire hit_node  = req.addr == OFS_MASTER_NODE;
  wire hit_any   = hit_sel | hit_sp | hit_mask | hit_saddr | hit_spar | hit_taddr |
                   hit_tpar | hit_fac | hit_sbaud | hit_tbaud | hit_node;
  wire sp_ok     = req.wdata[31:0] <= {16'h0000, SP_FULL_SCALE};
  wire par_ok    = req.wdata <= 32'h0000_0002;
  wire fac_ok    = req.wdata <= SLV_FACTOR_MAX;
  wire node_ok   = (req.wdata >= 32'h0000_0001) && (req.wdata <= {24'h00_0000, NODE_MAX});
  wire sel_ok    = req.wdata <= 32'h0000_0001;
  wire mask_ok   = req.wdata <= 32'h0000_000f;
  wire byte_ok   = req.wdata <= 32'h0000_00ff;
  wire val_ok    = hit_sp ? sp_ok :
                   (hit_spar | hit_tpar) ? par_ok :
                   hit_fac ? fac_ok :
                   hit_node ? node_ok :
                   hit_sel ? sel_ok :
                   hit_mask ? mask_ok :
                   (hit_saddr | hit_taddr) ? byte_ok : 1'b1;
  wire wr_ok     = wr && hit_any && val_ok;
  wire [31:0] rd_mux =
    hit_sel   ? {24'h00_0000, limit_sel_r} :
    hit_sp    ? {16'h0000, safe_sp_r} :
    hit_mask  ? {24'h00_0000, rst_mask_r} :
    hit_saddr ? {24'h00_0000, side_addr_r} :
    hit_spar  ? {24'h00_0000, side_par_r} :
    hit_taddr ? {24'h00_0000, top_addr_r} :
    hit_tpar  ? {24'h00_0000, top_par_r} :
    hit_fac   ? slv_factor_r :
    hit_sbaud ? side_baud_r :
    hit_tbaud ? top_baud_r :
    hit_node  ? {24'h00_0000, master_node_r} : 32'h0000_0000;

  assign req_ack = acc;
  assign req_err = acc && (!hit_any || (req.wr && !val_ok));

  // ------------------------------------------------------------
  // Counter limit state
  // ------------------------------------------------------------
  // Limit event in mode 2 only
  wire limit_evt = counter_at_limit && (counter_mode == CNT_MODE_LIMIT);
  wire reset_hit = (rst_switch && rst_mask_r[RM_SWITCH_BIT]) ||
                   (rst_extern && rst_mask_r[RM_EXTERN_BIT]) ||
                   (rst_param && rst_mask_r[RM_PARAM_BIT]) ||
                   (counter_cleared && rst_mask_r[RM_AUTO_BIT]);

  always_comb begin
    cstate_nxt = cstate_r;
    unique case (cstate_r)
      CS_RUN: begin
        if (limit_evt && limit_sel_r == SEL_SAFE) cstate_nxt = CS_SAFE;
      end
      CS_SAFE: begin
        if (reset_hit) cstate_nxt = CS_RUN;
      end
      default: cstate_nxt = CS_RUN;
    endcase
  end

  assign safe_active  = cstate_r == CS_SAFE;
  assign effective_sp = safe_active ? safe_sp_r : present_sp;

  // ------------------------------------------------------------
  // Slave setpoint
  // ------------------------------------------------------------
  // Slave control modes
  wire slave_mode = (control_mode == CTRL_SLAVE_DIG) || (control_mode == CTRL_SLAVE_ANA);
  wire factor_on  = net_is_fieldbus ? slave_mode :
                    (control_mode == CTRL_SLAVE_ANA) && analog_master_fed;
  wire [47:0] prod     = {32'h0000_0000, master_output} * {16'h0000, slv_factor_r};
  wire [47:0] quot     = prod / {16'h0000, PERCENT_FULL};
  wire [15:0] slave_nx = (quot > {32'h0000_0000, SP_FULL_SCALE}) ? SP_FULL_SCALE : quot[15:0];
  assign slave_active = factor_on;
  assign slave_sp     = slave_sp_r;
  assign poll_req     = poll_r;
  assign poll_node    = master_node_r;
  assign published_output = pub_r;
  assign rdata    = rdata_r;
  assign cfg_mode = cfg_mode_r;
  assign top_cfg  = '{addr: top_addr_r, baud: top_baud_r, parity: decode_parity(top_par_r)};
  assign side_cfg = '{addr: side_addr_r, baud: side_baud_r, parity: decode_parity(side_par_r)};

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_mask_r  <= RST_RST_MASK;
      limit_sel_r <= RST_LIMIT_SEL;
      safe_sp_r   <= RST_SAFE_SP;
      cstate_r    <= CS_RUN;
      rdata_r     <= 32'h0000_0000;
    end else begin
      cstate_r <= cstate_nxt;
      if (acc && req.rd) rdata_r <= rd_mux;
      if (factory_restore) begin
        rst_mask_r  <= RST_RST_MASK;
        limit_sel_r <= RST_LIMIT_SEL;
        safe_sp_r   <= RST_SAFE_SP;
      end else if (wr_ok) begin
        if (hit_sel)  limit_sel_r <= req.wdata[7:0];
        if (hit_sp)   safe_sp_r   <= req.wdata[15:0];
        if (hit_mask) rst_mask_r  <= req.wdata[7:0];
      end
    end
  end

  // Top port writes accepted from RS232 in configuration mode or when side port is not RS485
  always_ff @(posedge clk) begin
    if (srst) begin
      top_addr_r    <= RST_NODE_ADDR;
      top_par_r     <= RST_PARITY;
      top_baud_r    <= RST_BAUD;
      side_addr_r   <= RST_NODE_ADDR;
      side_par_r    <= RST_PARITY;
      side_baud_r   <= RST_BAUD;
      slv_factor_r  <= RST_SLV_FACTOR;
      master_node_r <= RST_MASTER_NODE;
    end else if (wr_ok) begin
      if (hit_taddr) top_addr_r    <= req.wdata[7:0];
      if (hit_tpar)  top_par_r     <= req.wdata[7:0];
      if (hit_tbaud) top_baud_r    <= req.wdata;
      if (hit_saddr) side_addr_r   <= req.wdata[7:0];
      if (hit_spar)  side_par_r    <= req.wdata[7:0];
      if (hit_sbaud) side_baud_r   <= req.wdata;
      if (hit_fac)   slv_factor_r  <= req.wdata;
      if (hit_node)  master_node_r <= req.wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_mode_r   <= 1'b0;
      cfg_loaded_r <= 1'b0;
    end else begin
      cfg_loaded_r <= 1'b1;
      if (!cfg_loaded_r) cfg_mode_r <= cfg_mode_stored;
      else if (switch_cfg_toggle) cfg_mode_r <= !cfg_mode_r;
    end
  end

  // Own output kept for all nodes
  always_ff @(posedge clk) begin
    if (srst) begin
      poll_cnt_r <= 32'h0000_0000;
      poll_r     <= 1'b0;
      slave_sp_r <= 16'h0000;
      pub_r      <= 16'h0000;
    end else begin
      pub_r  <= own_output;
      poll_r <= 1'b0;
      if (slave_mode && net_is_fieldbus) begin
        if (poll_cnt_r >= 32'(POLL_LEN - 1)) begin
          poll_cnt_r <= 32'h0000_0000;
          poll_r     <= 1'b1;
        end else begin
          poll_cnt_r <= poll_cnt_r + 32'h0000_0001;
        end
      end else begin
        poll_cnt_r <= 32'h0000_0000;
      end
      if (master_output_vld && factor_on) slave_sp_r <= slave_nx;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_limit_safe;
    limit_evt && limit_sel_r == SEL_SAFE && !safe_active;
  endsequence

  a_limit_safe_entry: assert property (@(posedge clk) disable iff (srst)
    s_limit_safe |=> safe_active && effective_sp == safe_sp_r) else $error("no safe entry");
  a_limit_keep_sp: assert property (@(posedge clk) disable iff (srst)
    !safe_active |-> effective_sp == present_sp) else $error("setpoint changed");
  a_safe_hold: assert property (@(posedge clk) disable iff (srst)
    safe_active && !reset_hit |=> safe_active) else $error("safe dropped");
  a_safe_range: assert property (@(posedge clk) disable iff (srst)
    safe_sp_r <= SP_FULL_SCALE) else $error("safe setpoint range");
  a_mask_reset: assert property (@(posedge clk) disable iff (srst)
    safe_active && rst_param && !rst_mask_r[RM_PARAM_BIT] && !rst_switch && !rst_extern
    && !counter_cleared |=> safe_active) else $error("masked reset acted");
  a_mask_init: assert property (@(posedge clk)
    $fell(srst) |-> rst_mask_r == RST_RST_MASK) else $error("mask init");
  a_parity_dec: assert property (@(posedge clk) disable iff (srst)
    (top_par_r <= 8'h02) && (top_cfg.parity != PAR_BAD)) else $error("parity decode");
  a_net_keep: assert property (@(posedge clk) disable iff (srst)
    factory_restore && !wr_ok |=> $stable(top_baud_r) && $stable(side_addr_r))
    else $error("network lost");
  sequence s_cfg_switch;
    cfg_loaded_r && switch_cfg_toggle;
  endsequence
  a_cfg_toggle: assert property (@(posedge clk) disable iff (srst)
    s_cfg_switch |=> cfg_mode != $past(cfg_mode))
    else $error("config toggle lost");
  sequence s_rs232_top_wr;
    req.wr && req_rs232 && (!side_rs485 || cfg_mode_r) && req.addr == OFS_TOP_ADDR
    && req.wdata <= 32'h0000_00ff;
  endsequence
  a_rs232_top_wr: assert property (@(posedge clk) disable iff (srst)
    s_rs232_top_wr |=> top_cfg.addr == $past(req.wdata[7:0]))
    else $error("rs232 top write lost");
  a_pub_follow: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> published_output == $past(own_output))
    else $error("output not published");
  a_factor_gate: assert property (@(posedge clk) disable iff (srst)
    !net_is_fieldbus && !(control_mode == CTRL_SLAVE_ANA && analog_master_fed)
    |-> !slave_active)
    else $error("factor gate open");
  a_rs232_block: assert property (@(posedge clk) disable iff (srst)
    req.wr && req_rs232 && side_rs485 && !cfg_mode |-> !req_ack) else $error("rs232 taken");
  a_poll_period: assert property (@(posedge clk) disable iff (srst)
    poll_r |=> !poll_r) else $error("poll too fast");
  a_node_range: assert property (@(posedge clk) disable iff (srst)
    master_node_r >= 8'h01 && master_node_r <= NODE_MAX) else $error("node range");
  a_slave_calc: assert property (@(posedge clk) disable iff (srst)
    master_output_vld && factor_on |=> slave_sp == $past(slave_nx)) else $error("slave sp");
endmodule

/* testbench/clbc_master_model.sv */
/*
  Model of the master instrument on the proprietary fieldbus, answering polls.
  Assumes poll_req is a one cycle pulse; slow stretches the answer delay.
*/
`timescale 1ns/1ns
module clbc_master_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        poll_req,
  input  wire logic [15:0] value,
  output logic [15:0]      master_output,
  output logic             master_output_vld
);
  int unsigned wait_r;
  logic [15:0] last_r;
  initial begin
    wait_r = 0;
    last_r = 16'h0000;
    master_output = 16'hffff;
    master_output_vld = 1'b0;
  end
  always @(posedge clk) begin
    master_output_vld <= 1'b0;
    master_output <= ~last_r;
    if (poll_req) begin
      wait_r <= slow ? 6 : 1;
    end else if (wait_r == 1) begin
      master_output_vld <= 1'b1;
      master_output <= value;
      last_r <= value;
      wait_r <= 0;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule

/* testbench/tb_clbc_top.sv */
/*
  Self-checking bench of the counter limit and bus config block.
  Assumes the access contract of the block and a short poll period.
*/
`timescale 1ns/1ns
module tb_clbc_top
  import clbc_pkg::*;
;
  localparam int PL = 8;
  localparam logic [15:0] ADR [11] = '{OFS_LIMIT_SEL, OFS_SAFE_SP, OFS_RST_MASK,
    OFS_SIDE_ADDR, OFS_SIDE_PAR, OFS_TOP_ADDR, OFS_TOP_PAR, OFS_SLV_FACTOR,
    OFS_SIDE_BAUD, OFS_TOP_BAUD, OFS_MASTER_NODE};
  localparam logic [31:0] RSTV [11] = '{RST_LIMIT_SEL, RST_SAFE_SP, RST_RST_MASK,
    RST_NODE_ADDR, RST_PARITY, RST_NODE_ADDR, RST_PARITY, RST_SLV_FACTOR,
    RST_BAUD, RST_BAUD, RST_MASTER_NODE};
  localparam int          BI [8] = '{1, 4, 6, 7, 10, 10, 0, 2};
  localparam logic [31:0] BD [8] = '{32'h0000_7d01, 32'h0000_0003, 32'h0000_0003,
    32'h0000_01f5, 32'h0000_0000, 32'h0000_0081, 32'h0000_0002, 32'h0000_0010};
  logic           clk, srst, req_rs232, side_rs485, cfg_mode_stored, switch_cfg_toggle;
  logic           factory_restore, counter_at_limit, rst_switch, rst_extern, rst_param;
  logic           counter_cleared, net_is_fieldbus, analog_master_fed, master_output_vld;
  logic           req_ack, req_err, cfg_mode, safe_active, slave_active, poll_req, slow;
  logic [1:0]     counter_mode;
  logic [7:0]     control_mode, poll_node;
  logic [15:0]    present_sp, master_output, own_output, effective_sp, slave_sp, mval;
  logic [15:0]    published_output, e;
  logic [31:0]    rdata, rv, f, node;
  logic [31:0]    sh [11];
  clbc_req_t      req;
  clbc_port_cfg_t top_cfg, side_cfg;
  int             miscompares, n_checks, n;

  clbc_top #(.POLL_LEN(PL)) uut (.clk(clk), .srst(srst), .req(req), .req_rs232(req_rs232),
    .side_rs485(side_rs485), .cfg_mode_stored(cfg_mode_stored),
    .switch_cfg_toggle(switch_cfg_toggle), .factory_restore(factory_restore),
    .counter_mode(counter_mode), .counter_at_limit(counter_at_limit),
    .rst_switch(rst_switch), .rst_extern(rst_extern), .rst_param(rst_param),
    .counter_cleared(counter_cleared), .present_sp(present_sp),
    .control_mode(control_mode), .net_is_fieldbus(net_is_fieldbus),
    .analog_master_fed(analog_master_fed), .master_output(master_output),
    .master_output_vld(master_output_vld), .own_output(own_output), .req_ack(req_ack),
    .req_err(req_err), .rdata(rdata), .cfg_mode(cfg_mode), .effective_sp(effective_sp),
    .safe_active(safe_active), .slave_active(slave_active), .poll_req(poll_req),
    .poll_node(poll_node), .slave_sp(slave_sp), .published_output(published_output),
    .top_cfg(top_cfg), .side_cfg(side_cfg));
  clbc_master_model pm (.clk(clk), .slow(slow), .poll_req(poll_req), .value(mval),
    .master_output(master_output), .master_output_vld(master_output_vld));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic ea, input logic ee);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    #2;
    chk("req_ack", {31'b0, ea}, {31'b0, req_ack});
    if (ea) begin
      chk("req_err", {31'b0, ee}, {31'b0, req_err});
    end
    @(negedge clk);
    req = '0;
    rv = rdata;
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    case (k)
      0: rst_switch = 1'b1;
      1: rst_extern = 1'b1;
      2: rst_param = 1'b1;
      3: counter_cleared = 1'b1;
      4: switch_cfg_toggle = 1'b1;
      default: factory_restore = 1'b1;
    endcase
    @(negedge clk);
    {rst_switch, rst_extern, rst_param, counter_cleared} = 4'h0;
    {switch_cfg_toggle, factory_restore} = 2'h0;
  endtask
  task automatic look(input logic s, input logic [15:0] sp);
    repeat (2) @(negedge clk);
    chk("safe_active", {31'b0, s}, {31'b0, safe_active});
    chk("effective_sp", {16'h0000, sp}, {16'h0000, effective_sp});
  endtask
  task automatic hit();
    @(negedge clk);
    counter_at_limit = 1'b1;
    @(negedge clk);
    counter_at_limit = 1'b0;
  endtask
  task automatic do_reset();
    @(negedge clk);
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
  endtask
  function automatic logic [31:0] legal(input int i, input int r);
    case (i)
      0: return $urandom % 2;
      1: return $urandom % 32001;
      2: return $urandom % 16;
      4, 6: return (r + i) % 3;
      7: return $urandom % 501;
      8, 9: return $urandom;
      10: return 1 + $urandom % 128;
      default: return $urandom % 256;
    endcase
  endfunction
  function automatic logic [15:0] exp_slave(input int unsigned m, input int unsigned fc);
    int unsigned p;
    p = m * fc / 100;
    return (p > 32000) ? 16'h7d00 : p[15:0];
  endfunction
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    req = '0;
    {req_rs232, side_rs485, cfg_mode_stored, switch_cfg_toggle, factory_restore} = 5'h00;
    {counter_at_limit, rst_switch, rst_extern, rst_param, counter_cleared} = 5'h00;
    {net_is_fieldbus, analog_master_fed, slow} = 3'h4;
    counter_mode = 2'h0;
    control_mode = 8'h00;
    {present_sp, own_output, mval} = '0;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'hb31e));
    do_reset();
    for (int i = 0; i < 11; i++) begin
      acc(0, ADR[i], 0, 1, 0);
      chk("reset value", RSTV[i], rv); // defaults
    end
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 11; i++) begin
        sh[i] = legal(i, r);
        acc(1, ADR[i], sh[i], 1, 0); // legal ranges
      end
      for (int i = 0; i < 11; i++) begin
        acc(0, ADR[i], 0, 1, 0);
        chk("readback", sh[i], rv);
      end
      chk("top parity", sh[6], {30'b0, top_cfg.parity}); // parity decode
      chk("side parity", sh[4], {30'b0, side_cfg.parity}); // parity decode
      chk("top baud", sh[9], top_cfg.baud);
      chk("side addr", sh[3], {24'b0, side_cfg.addr});
      chk("top addr", sh[5], {24'b0, top_cfg.addr}); // top port config
      chk("side baud", sh[8], side_cfg.baud); // side port config
    end
    for (int k = 0; k < 8; k++) begin
      acc(1, ADR[BI[k]], BD[k], 1, 1); // refused values
      acc(0, ADR[BI[k]], 0, 1, 0);
      chk("kept after refusal", sh[BI[k]], rv);
    end
    acc(0, 16'h0d07, 0, 1, 1);
    chk("unmapped rdata", 32'h0000_0000, rv);
    acc(1, OFS_RST_MASK, 0, 1, 0);
    pulse(5);
    acc(0, OFS_RST_MASK, 0, 1, 0);
    chk("mask after restore", RST_RST_MASK, rv); // restore value
    for (int i = 3; i < 10; i++) begin
      acc(0, ADR[i], 0, 1, 0);
      chk("network after restore", sh[i], rv); // network kept
    end
    present_sp = 16'h1234;
    acc(1, OFS_SAFE_SP, 32'h0000_3e80, 1, 0);
    for (int m = 0; m < 4; m++) begin
      acc(1, OFS_RST_MASK, 1 << m, 1, 0);
      acc(1, OFS_LIMIT_SEL, 1, 1, 0);
      counter_mode = 2'h1;
      hit();
      look(1'b0, present_sp); // no limit in mode 1
      counter_mode = 2'h2;
      hit();
      look(1'b1, 16'h3e80); // safe setpoint applied
      pulse((m + 1) % 4);
      look(1'b1, 16'h3e80); // disabled method ignored
      pulse(m);
      look(1'b0, present_sp); // enabled method releases
    end
    acc(1, OFS_LIMIT_SEL, 0, 1, 0);
    hit();
    look(1'b0, present_sp); // setpoint kept
    side_rs485 = 1'b1;
    req_rs232 = 1'b1;
    acc(1, OFS_TOP_ADDR, 32'h0000_0055, 0, 0); // RS232 ignored
    req_rs232 = 1'b0;
    acc(0, OFS_TOP_ADDR, 0, 1, 0);
    chk("top addr kept", sh[5], rv); // no effect
    pulse(4);
    chk("cfg_mode on", 1, {31'b0, cfg_mode}); // switch enters
    req_rs232 = 1'b1;
    acc(1, OFS_TOP_ADDR, 32'h0000_0055, 1, 0); // RS232 write
    acc(0, OFS_TOP_ADDR, 0, 1, 0);
    chk("top addr written", 32'h0000_0055, rv); // RS232 write
    cfg_mode_stored = 1'b1;
    do_reset();
    chk("cfg_mode kept", 1, {31'b0, cfg_mode}); // survives restart
    pulse(4);
    chk("cfg_mode off", 0, {31'b0, cfg_mode}); // switch leaves
    acc(1, OFS_TOP_ADDR, 32'h0000_0066, 0, 0); // blocked again
    req_rs232 = 1'b0;
    for (int k = 0; k < 4; k++) begin
      control_mode = k[0] ? CTRL_SLAVE_ANA : CTRL_SLAVE_DIG;
      slow = k[1];
      f = (k == 3) ? 32'h0000_01f4 : $urandom % 501;
      node = 1 + $urandom % 128;
      mval = (k == 3) ? 16'h7d00 : 16'($urandom % 32001);
      own_output = 16'($urandom);
      acc(1, OFS_SLV_FACTOR, f, 1, 0);
      acc(1, OFS_MASTER_NODE, node, 1, 0);
      chk("slave_active", 1, {31'b0, slave_active}); // slave modes
      for (n = 0; n < 3 * PL && poll_req !== 1'b1; n++) @(negedge clk);
      bound(n, 3 * PL); // periodic poll
      chk("poll_node", node, {24'b0, poll_node}); // master node
      e = exp_slave(mval, f);
      for (n = 0; n < 20 && slave_sp !== e; n++) @(negedge clk);
      chk("slave_sp", {16'h0000, e}, {16'h0000, slave_sp}); // scaled setpoint
      chk("published", {16'h0000, own_output}, {16'h0000, published_output});
    end
    net_is_fieldbus = 1'b0;
    n = 0;
    repeat (3 * PL) begin
      @(negedge clk);
      n += (poll_req === 1'b1) ? 1 : 0;
    end
    chk("polls off bus", 0, n); // fieldbus only
    chk("slave unfed", 0, {31'b0, slave_active}); // analog feed needed
    analog_master_fed = 1'b1;
    @(negedge clk);
    chk("slave analog fed", 1, {31'b0, slave_active}); // analog slave scaled
    control_mode = CTRL_SLAVE_DIG;
    @(negedge clk);
    chk("slave digital off bus", 0, {31'b0, slave_active}); // digital not scaled
    control_mode = 8'h00;
    @(negedge clk);
    chk("slave off", 0, {31'b0, slave_active}); // other modes
    complete_run();
  end
endmodule
